// [rtl/scbc_pkg.sv]
// Shared constants and types of the synchronous bus-cycle master
package scbc_pkg;

	// ****************************************
	// Bus geometry and codes
	// ****************************************
	localparam int           SCBC_DATA_W       = 32;
	localparam int           SCBC_LANES        = 4;
	localparam logic [1:0]   SCBC_SIZE_WORD    = 2'h0;
	localparam logic [1:0]   SCBC_SIZE_BYTE    = 2'h1;
	localparam logic [1:0]   SCBC_SIZE_HALF    = 2'h2;
	localparam logic [1:0]   SCBC_CS_DELAY_0   = 2'h0;
	localparam logic [1:0]   SCBC_CS_DELAY_Q   = 2'h2;
	localparam logic [1:0]   SCBC_CS_DELAY_H   = 2'h3;
	localparam logic [1:0]   SCBC_BURST_LAST   = 2'h3;
	localparam logic [3:0]   SCBC_LANES_ALL    = 4'hF;
	localparam logic [3:0]   SCBC_LANES_HALF   = 4'hC;
	localparam logic [3:0]   SCBC_LANES_BYTE   = 4'h8;
	localparam bit           SCBC_PARITY_ODD   = 1'b1;

	// ****************************************
	// Timing
	// ****************************************
	localparam int           SCBC_CLK_PERIOD_NS = 100;
	localparam int           SCBC_TIMEOUT_NS    = 25600;
	localparam int           SCBC_TIMEOUT_CYC   = (SCBC_TIMEOUT_NS / SCBC_CLK_PERIOD_NS < 1) ? 1 :
		SCBC_TIMEOUT_NS / SCBC_CLK_PERIOD_NS;
	localparam int           SCBC_TO_W          = $clog2(SCBC_TIMEOUT_CYC + 1);

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed
	{
		logic [0:31] addr;
		logic [1:0]  size;
		logic        write;
		logic        burst;
		logic [0:3]  atype;
		logic [0:31] wdata;
	} scbc_req_t;

	typedef struct packed
	{
		logic [0:31] rdata;
		logic        error;
		logic        timeout;
		logic        parity_err;
		logic        last;
	} scbc_rsp_t;

	typedef struct packed
	{
		logic [0:31] cs_base_setting;
		logic [0:31] cs_mask;
		logic [1:0]  cs_delay_field;
		logic        early_negate_bit;
		logic        relaxed_timing_bit;
		logic        extended_hold_bit;
		logic [3:0]  wait_states;
		logic        ext_ack_mode;
		logic        auto_burst_inhibit;
	} scbc_cs_cfg_t;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_SETUP, ST_ACCESS, ST_DONE} scbc_state_t;

endpackage

// [rtl/scbc_lane_parity.sv]
// Per-byte-lane parity of a big-endian numbered 32-bit word
module scbc_lane_parity
	import scbc_pkg::*;
#(
	parameter bit ODD = SCBC_PARITY_ODD
)
(
	input  wire logic [0:31] word,
	output logic      [0:3]  par
);

	always_comb
	begin
		for (int i = 0; i < SCBC_LANES; i++)
		begin
			par[i] = (^word[i*8 +: 8]) ^ ODD;
		end
	end

endmodule // scbc_lane_parity

// [rtl/scbc_bus_master.sv]
// Bus controller with one general chip select, master end of the synchronous system bus
module scbc_bus_master
	import scbc_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 srst,
	input  wire scbc_pkg::scbc_cs_cfg_t cs_cfg,
	input  wire logic                 req_valid,
	output logic                      req_ready,
	input  wire scbc_pkg::scbc_req_t  req,
	output logic                      rsp_valid,
	output scbc_pkg::scbc_rsp_t       rsp,
	output logic [0:31]               bus_addr,
	output logic                      transfer_start_n,
	output logic [0:1]                transfer_size_code,
	output logic                      rd_wr,
	output logic [0:3]                address_type_code,
	input  wire logic [0:31]          data_in,
	output logic [0:31]               data_out,
	output logic                      data_oe,
	input  wire logic [0:3]           parity_in,
	output logic [0:3]                parity_out,
	output logic                      parity_oe,
	input  wire logic                 transfer_ack_n,
	input  wire logic                 transfer_error_ack_n,
	output logic                      transfer_error_ack_n_out,
	output logic                      transfer_error_ack_oe,
	input  wire logic                 burst_inhibit_n,
	output logic                      burst_inhibit_n_out,
	output logic                      burst_inhibit_oe,
	output logic                      burst_in_progress_n,
	output logic                      cs_n,
	output logic                      oe_n,
	output logic [0:3]                we_n
);
	import scbc_pkg::*;

	// ****************************************
	// Helpers
	// ****************************************
	function automatic logic [3:0] lane_mask(input logic [1:0] size);
		case (size)
			SCBC_SIZE_BYTE: lane_mask = SCBC_LANES_BYTE;
			SCBC_SIZE_HALF: lane_mask = SCBC_LANES_HALF;
			default:        lane_mask = SCBC_LANES_ALL;
		endcase
	endfunction

	// Word cycles drive address bits 30:31 zero and half-word cycles bit 30, so the slave sees a clean address
	function automatic logic [0:31] trim_addr(input logic [0:31] a, input logic [1:0] size);
		logic [0:31] t;
		t = a;
		if (size == SCBC_SIZE_WORD)
		begin
			t[30:31] = 2'h0;
		end
		else if (size == SCBC_SIZE_HALF)
		begin
			t[30] = 1'b0;
		end
		trim_addr = t;
	endfunction

	// ****************************************
	// State
	// ****************************************
	scbc_state_t          state_ff;
	scbc_state_t          nxt_state;
	logic [0:31]          addr_ff;
	logic [1:0]           size_ff;
	logic                 write_ff;
	logic [0:3]           atype_ff;
	logic [0:31]          wdata_ff;
	logic                 burst_ff;
	logic                 burst_mode_ff;
	logic [1:0]           beat_ff;
	logic                 hit_ff;
	logic                 prev_hit_ff;
	logic [1:0]           setup_ff;
	logic [3:0]           wait_ff;
	logic [SCBC_TO_W-1:0] to_ff;
	logic                 rsp_valid_ff;
	scbc_rsp_t            rsp_ff;
	logic [0:3]           gen_par;
	logic [0:3]           chk_par;
	logic                 internal_end;
	logic                 timeout_hit;
	logic                 is_err;
	logic                 beat_end;
	logic                 inhibit;
	logic                 more_beats;
	logic                 req_hit;
	logic [1:0]           setup_need;
	logic [3:0]           lanes;

	assign req_hit      = ((req.addr ^ cs_cfg.cs_base_setting) & cs_cfg.cs_mask) == 32'h0;
	assign internal_end = hit_ff && !cs_cfg.ext_ack_mode;
	assign timeout_hit  = to_ff == SCBC_TO_W'(SCBC_TIMEOUT_CYC - 1);
	assign is_err       = !transfer_error_ack_n || timeout_hit;
	assign beat_end     = (state_ff == ST_ACCESS) &&
		(is_err || (internal_end ? (wait_ff == 4'h0) : !transfer_ack_n));
	assign inhibit      = !burst_inhibit_n || (hit_ff && cs_cfg.auto_burst_inhibit);
	assign more_beats   = burst_ff && (beat_ff != SCBC_BURST_LAST) && !is_err;
	assign lanes        = lane_mask(size_ff);

	// Sub-clock delays cannot be placed on a single edge; SCBC_CS_DELAY_Q and SCBC_CS_DELAY_H each cost one clock
	always_comb
	begin
		setup_need = 2'h0;
		if (hit_ff)
		begin
			setup_need = 2'(cs_cfg.relaxed_timing_bit)
				+ 2'(cs_cfg.cs_delay_field == SCBC_CS_DELAY_Q || cs_cfg.cs_delay_field == SCBC_CS_DELAY_H)
				+ 2'(cs_cfg.extended_hold_bit && !prev_hit_ff);
		end
	end

	// ****************************************
	// Sequencer
	// ****************************************
	always_comb
	begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
			begin
				if (req_valid && transfer_ack_n)
				begin
					nxt_state = ST_START;
				end
			end
			ST_START:
			begin
				nxt_state = (setup_need == 2'h0) ? ST_ACCESS : ST_SETUP;
			end
			ST_SETUP:
			begin
				if (setup_ff == 2'h1)
				begin
					nxt_state = ST_ACCESS;
				end
			end
			ST_ACCESS:
			begin
				if (beat_end)
				begin
					if (!more_beats)
					begin
						nxt_state = ST_DONE;
					end
					else if (!burst_mode_ff || inhibit)
					begin
						nxt_state = ST_START;
					end
				end
			end
			ST_DONE:
			begin
				nxt_state = ST_IDLE;
			end
			default:
			begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			state_ff <= ST_IDLE;
		end
		else
		begin
			state_ff <= nxt_state;
		end
	end

	// ****************************************
	// Transfer attributes
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			addr_ff       <= 32'h0;
			size_ff       <= SCBC_SIZE_WORD;
			write_ff      <= 1'b0;
			atype_ff      <= 4'h0;
			wdata_ff      <= 32'h0;
			burst_ff      <= 1'b0;
			burst_mode_ff <= 1'b0;
			beat_ff       <= 2'h0;
			hit_ff        <= 1'b0;
		end
		else if (state_ff == ST_IDLE && nxt_state == ST_START)
		begin
			// Bursts are cache fills: reads only, always word wide
			burst_ff      <= req.burst && !req.write;
			burst_mode_ff <= req.burst && !req.write;
			size_ff       <= (req.burst && !req.write) ? SCBC_SIZE_WORD : req.size;
			addr_ff       <= trim_addr(req.addr, (req.burst && !req.write) ? SCBC_SIZE_WORD : req.size);
			write_ff      <= req.write;
			atype_ff      <= req.atype;
			wdata_ff      <= req.wdata;
			beat_ff       <= 2'h0;
			hit_ff        <= req_hit;
		end
		else if (beat_end && more_beats)
		begin
			beat_ff <= beat_ff + 2'h1;
			if (!burst_mode_ff || inhibit)
			begin
				// Leftover words go out as single cycles at their own address
				burst_mode_ff <= 1'b0;
				addr_ff       <= burst_mode_ff ? addr_ff + {28'h0, beat_ff + 2'h1, 2'h0}
					: addr_ff + 32'h4;
			end
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			prev_hit_ff <= 1'b0;
		end
		else if (state_ff == ST_DONE)
		begin
			prev_hit_ff <= hit_ff;
		end
	end

	// ****************************************
	// Counters
	// ****************************************
	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			setup_ff <= 2'h0;
		end
		else if (state_ff == ST_START)
		begin
			setup_ff <= setup_need;
		end
		else if (state_ff == ST_SETUP)
		begin
			setup_ff <= setup_ff - 2'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			wait_ff <= 4'h0;
		end
		else if (state_ff == ST_START || (beat_end && more_beats))
		begin
			wait_ff <= cs_cfg.wait_states;
		end
		else if (state_ff == ST_ACCESS && wait_ff != 4'h0)
		begin
			wait_ff <= wait_ff - 4'h1;
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			to_ff <= '0;
		end
		else if (state_ff != ST_ACCESS || beat_end)
		begin
			to_ff <= '0;
		end
		else
		begin
			to_ff <= to_ff + SCBC_TO_W'(1);
		end
	end

	// ****************************************
	// Answer to the requester
	// ****************************************
	scbc_lane_parity u_par_gen
	(
		.word (wdata_ff),
		.par  (gen_par)
	);

	scbc_lane_parity u_par_chk
	(
		.word (data_in),
		.par  (chk_par)
	);

	always_ff @(posedge mclk)
	begin
		if (srst)
		begin
			rsp_valid_ff <= 1'b0;
			rsp_ff       <= '0;
		end
		else
		begin
			rsp_valid_ff <= beat_end;
			if (beat_end)
			begin
				rsp_ff.rdata      <= write_ff ? 32'h0 : data_in;
				rsp_ff.error      <= is_err;
				rsp_ff.timeout    <= timeout_hit;
				rsp_ff.parity_err <= !write_ff && !is_err && ((chk_par ^ parity_in) & lanes) != 4'h0;
				rsp_ff.last       <= !more_beats;
			end
		end
	end

	assign rsp_valid = rsp_valid_ff;
	assign rsp       = rsp_ff;
	assign req_ready = (state_ff == ST_IDLE) && transfer_ack_n;

	// ****************************************
	// Bus pins
	// ****************************************
	logic cs_on;
	assign cs_on = hit_ff && state_ff == ST_ACCESS &&
		!(cs_cfg.early_negate_bit && internal_end && cs_cfg.wait_states != 4'h0 && wait_ff == 4'h0);

	assign bus_addr                 = addr_ff;
	assign transfer_start_n         = state_ff != ST_START;
	assign transfer_size_code       = size_ff;
	assign rd_wr                    = !write_ff;
	assign address_type_code        = atype_ff;
	assign data_out                 = wdata_ff;
	assign data_oe                  = write_ff && (state_ff == ST_SETUP || state_ff == ST_ACCESS);
	assign parity_out               = gen_par;
	assign parity_oe                = data_oe;
	assign transfer_error_ack_n_out = 1'b0;
	assign transfer_error_ack_oe    = state_ff == ST_ACCESS && timeout_hit;
	assign burst_inhibit_n_out      = 1'b0;
	assign burst_inhibit_oe         = state_ff == ST_ACCESS && hit_ff && cs_cfg.auto_burst_inhibit;
	assign burst_in_progress_n      = !(burst_mode_ff && beat_ff != SCBC_BURST_LAST &&
		state_ff != ST_IDLE && state_ff != ST_DONE);
	assign cs_n                     = !cs_on;
	assign oe_n                     = !(cs_on && !write_ff);
	assign we_n                     = ~((cs_on && write_ff) ? lanes : 4'h0);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	a_start_one_clock: assert property (!transfer_start_n |=> transfer_start_n)
		else $error("start strobe longer than one clock");
	a_size_word_burst: assert property (!burst_in_progress_n |->
		transfer_size_code == SCBC_SIZE_WORD && bus_addr[30:31] == 2'h0)
		else $error("burst not word wide or not aligned");
	a_dir_held: assert property ((state_ff == ST_ACCESS) && $past(state_ff == ST_ACCESS) |->
		$stable(rd_wr) && $stable(bus_addr))
		else $error("direction or address moved inside a transfer");
	a_no_start_ack: assert property (!transfer_ack_n |-> transfer_start_n)
		else $error("transfer started while acknowledge active");
	a_two_clock_min: assert property (!transfer_start_n |=> !rsp_valid ##1 1'b1)
		else $error("transaction shorter than two clocks");
	a_timeout_drive: assert property (transfer_error_ack_oe |->
		to_ff == SCBC_TO_W'(SCBC_TIMEOUT_CYC - 1) ##1 rsp_valid && rsp.error)
		else $error("time-out abort not reported");
	a_relaxed_setup: assert property (!transfer_start_n && hit_ff && cs_cfg.relaxed_timing_bit |=> cs_n)
		else $error("chip select not delayed");
	a_auto_inhibit: assert property (burst_inhibit_oe && beat_end && burst_ff && !is_err &&
		beat_ff != SCBC_BURST_LAST |=> !transfer_start_n && burst_in_progress_n)
		else $error("auto inhibit did not break burst");
	a_parity_out: assert property (data_oe |-> parity_oe && (^{data_out[0:7], parity_out[0]}) &&
		(^{data_out[8:15], parity_out[1]}) && (^{data_out[16:23], parity_out[2]}) &&
		(^{data_out[24:31], parity_out[3]}))
		else $error("write parity not odd or not driven");

endmodule // scbc_bus_master

// [verification/scbc_periph_model.sv]
// Peripheral slave model on the far side of the bus master
module scbc_periph_model
	import scbc_pkg::*;
#(
	parameter logic [0:31] KEY = 32'h5A5A_C3C3
)
(
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic [0:31] bus_addr,
	input  wire logic        transfer_start_n,
	input  wire logic        burst_in_progress_n,
	input  wire logic [0:31] data_out,
	input  wire logic [3:0]  mode,
	input  wire logic [3:0]  lat,
	input  wire logic        inhibit,
	output logic             ack_n,
	output logic             err_n,
	output logic             inh_n,
	output logic [0:31]      rdata,
	output logic [0:3]       rpar,
	output logic [0:31]      wr_seen
);
	timeunit 1ns;
	timeprecision 1ns;
	// ****
	// Mode 0 acks, 1 errors, 2 stays silent, 3 acks with bad parity
	// ****
	logic        busy_ff;
	logic [3:0]  cnt_ff;
	logic [1:0]  beat_ff;
	logic [0:31] base_ff;
	logic [0:31] word;

	// Word select advanced here, the master holds it
	assign word = (base_ff + {28'h0, beat_ff, 2'b00}) ^ KEY;

	always_ff @(posedge mclk)
	begin
		ack_n <= 1'b1;
		err_n <= 1'b1;
		inh_n <= 1'b1;
		// Released lines show a changing pattern, never the last value
		rdata <= ~rdata;
		rpar  <= ~rpar;
		if (srst)
		begin
			busy_ff <= 1'b0;
			rdata   <= '0;
			rpar    <= '0;
		end
		else if (!transfer_start_n)
		begin
			busy_ff <= (mode != 4'h2);
			cnt_ff  <= lat;
			base_ff <= bus_addr;
			beat_ff <= 2'h0;
		end
		else if (busy_ff && ack_n && cnt_ff != 4'h0)
			cnt_ff <= cnt_ff - 4'h1;
		else if (busy_ff && ack_n)
		begin
			ack_n   <= (mode == 4'h1);
			err_n   <= (mode != 4'h1);
			inh_n   <= !inhibit;
			rdata   <= word;
			rpar    <= ~{^word[0:7], ^word[8:15], ^word[16:23], ^word[24:31]} ^ {mode == 4'h3, 3'b000};
			wr_seen <= data_out;
			beat_ff <= beat_ff + 2'h1;
			cnt_ff  <= lat;
			busy_ff <= !burst_in_progress_n && !inhibit && beat_ff != 2'h3;
		end
	end
endmodule // scbc_periph_model

// [verification/tb_top.sv]
// Self-checking bench of the bus master
module tb_top
	import scbc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [0:31] KEY = 32'h5A5A_C3C3;
	logic         mclk, srst, req_valid, req_ready, rsp_valid, transfer_start_n, rd_wr, data_oe, parity_oe;
	logic         transfer_ack_n, transfer_error_ack_n, transfer_error_ack_n_out, transfer_error_ack_oe;
	logic         burst_inhibit_n, burst_inhibit_n_out, burst_inhibit_oe, burst_in_progress_n, cs_n, oe_n;
	logic         ack_p, err_p, inh_p, inhibit, rw_s, inh_seen, err_seen, burst_seen;
	logic [0:31]  bus_addr, data_in, data_out, wr_seen, a_s;
	logic [0:1]   transfer_size_code, sz_s;
	logic [0:3]   address_type_code, parity_in, parity_out, we_n, we_s, par_s, type_s;
	logic [3:0]   mode, lat;
	logic [1:0]   oe_s;
	scbc_cs_cfg_t cs_cfg;
	scbc_req_t    req;
	scbc_rsp_t    rsp;
	scbc_rsp_t    rs [4];
	int           err_total, comparisons, cyc, st_cyc, rsp_cyc, starts, prev_st, cs_cnt;

	// Open-drain lines: low when any party pulls
	assign transfer_error_ack_n = err_p && !(transfer_error_ack_oe && !transfer_error_ack_n_out);
	assign burst_inhibit_n = inh_p && !(burst_inhibit_oe && !burst_inhibit_n_out);
	assign transfer_ack_n = ack_p;

	scbc_bus_master uut
	(
		.mclk, .srst, .cs_cfg, .req_valid, .req_ready, .req, .rsp_valid, .rsp, .bus_addr,
		.transfer_start_n, .transfer_size_code, .rd_wr, .address_type_code, .data_in, .data_out,
		.data_oe, .parity_in, .parity_out, .parity_oe, .transfer_ack_n, .transfer_error_ack_n,
		.transfer_error_ack_n_out, .transfer_error_ack_oe, .burst_inhibit_n, .burst_inhibit_n_out,
		.burst_inhibit_oe, .burst_in_progress_n, .cs_n, .oe_n, .we_n
	);

	scbc_periph_model #(.KEY(KEY)) peer
	(
		.mclk, .srst, .bus_addr, .transfer_start_n, .burst_in_progress_n, .data_out, .mode, .lat,
		.inhibit, .ack_n(ack_p), .err_n(err_p), .inh_n(inh_p), .rdata(data_in), .rpar(parity_in), .wr_seen
	);

	// ****
	// Checking and bus monitor
	// ****
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic final_report();
		if (err_total == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk)
		cyc <= cyc + 1;

	always @(negedge mclk)
	begin
		if (!transfer_start_n)
		begin
			chk("start_gap", cyc - prev_st >= 2, 1);
			chk("start_ack", transfer_ack_n, 1);
			prev_st = cyc;
			st_cyc = cyc;
			starts++;
			a_s = bus_addr;
			sz_s = transfer_size_code;
			rw_s = rd_wr;
			type_s = address_type_code;
		end
		if (!ack_p)
		begin
			we_s = we_n;
			par_s = parity_out;
			oe_s = {oe_n, data_oe};
		end
		if (rsp_valid)
			rsp_cyc = cyc;
		if (!cs_n)
			cs_cnt++;
		inh_seen |= burst_inhibit_oe;
		err_seen |= transfer_error_ack_oe;
		burst_seen |= !burst_in_progress_n;
	end

	// ****
	// Transfer driver and scenarios
	// ****
	task automatic xfer(input logic [0:31] a, input logic [1:0] sz, input logic wr, input logic bu,
		input logic [0:31] wd, input int beats);
		int n;
		int got;
		n = 0;
		got = 0;
		@(negedge mclk);
		req = '{addr:a, size:sz, write:wr, burst:bu, atype:4'hA, wdata:wd};
		req_valid = 1'b1;
		while (!req_ready && n < 50)
		begin
			@(negedge mclk);
			n++;
		end
		@(negedge mclk);
		req_valid = 1'b0;
		while (got < beats && n < 400)
		begin
			if (rsp_valid)
			begin
				rs[got] = rsp;
				got++;
			end
			@(negedge mclk);
			n++;
		end
		if (n >= 400)
		begin
			chk("hang", 0, 1);
			final_report();
		end
	endtask

	task automatic t_read();
		logic [0:31] ea;
		for (int i = 0; i < 2; i++)
		begin
			lat = 4'(3 * i);
			ea = 32'h1234_5674 + 32'(16 * i);
			xfer(ea + 32'h3, SCBC_SIZE_WORD, 1'b0, 1'b0, 32'h0, 1);
			chk("rd_addr", a_s, ea);
			chk("rd_size", sz_s, SCBC_SIZE_WORD);
			chk("rd_dir", rw_s, 1);
			chk("rd_type", type_s, 4'hA);
			chk("rd_oe", oe_s, 2);
			chk("rd_data", rs[0].rdata, ea ^ KEY);
			chk("rd_perr", rs[0].parity_err, 0);
		end
		lat = 4'h0;
	endtask

	task automatic t_write();
		logic [1:0]  sz [3] = '{SCBC_SIZE_WORD, SCBC_SIZE_HALF, SCBC_SIZE_BYTE};
		logic [3:0]  we [3] = '{4'h0, 4'h3, 4'h7};
		logic [1:0]  lo [3] = '{2'h0, 2'h1, 2'h3};
		logic [31:0] mk [3] = '{32'hFFFF_FFFF, 32'hFFFF_0000, 32'hFF00_0000};
		for (int i = 0; i < 3; i++)
		begin
			xfer(32'h8000_0107, sz[i], 1'b1, 1'b0, 32'h1E2D_3C4B, 1);
			chk("wr_size", sz_s, sz[i]);
			chk("wr_dir", rw_s, 0);
			chk("wr_low", a_s[30:31], lo[i]);
			chk("wr_lanes", we_s, we[i]);
			chk("wr_oe", oe_s, 3);
			chk("wr_data", wr_seen & mk[i], 32'h1E2D_3C4B & mk[i]);
			chk("wr_par", par_s[0], ~^8'h1E);
		end
	endtask

	task automatic t_faults();
		for (int i = 1; i < 4; i++)
		begin
			mode = 4'(i);
			err_seen = 1'b0;
			xfer(32'h3000_0000, SCBC_SIZE_WORD, 1'b0, 1'b0, 32'h0, 1);
			chk("f_perr", rs[0].parity_err, i == 3);
			chk("f_tout", rs[0].timeout, i == 2);
			chk("f_err_drv", err_seen, i == 2);
			if (i < 3)
				chk("f_err", rs[0].error, 1);
		end
		mode = 4'h0;
	endtask

	task automatic t_burst();
		int          n0;
		logic [0:31] ba;
		// First pass hits the chip select, whose own inhibit must break the burst
		for (int i = 0; i < 3; i++)
		begin
			ba = (i == 0) ? 32'h8000_0010 : 32'h2000_0010;
			cs_cfg.auto_burst_inhibit = (i == 0);
			inhibit = (i == 2);
			n0 = starts;
			burst_seen = 1'b0;
			xfer(ba, SCBC_SIZE_WORD, 1'b0, 1'b1, 32'h0, 4);
			chk("b_starts", starts - n0, (i == 1) ? 1 : 4);
			chk("b_prog", burst_seen, 1);
			chk("b_oe", oe_s, (i == 0) ? 0 : 2);
			for (int b = 0; b < 4; b++)
			begin
				chk("b_data", rs[b].rdata, (ba + 32'(4 * b)) ^ KEY);
				chk("b_last", rs[b].last, b == 3);
			end
		end
		inhibit = 1'b0;
	endtask

	task automatic t_waits();
		int ws [7] = '{0, 0, 15, 0, 0, 0, 2};
		int rl [7] = '{0, 0, 0, 1, 0, 1, 0};
		int dl [7] = '{0, 0, 0, 0, 2, 3, 0};
		int eh [7] = '{1, 1, 0, 0, 0, 0, 0};
		int en [7] = '{0, 0, 0, 0, 0, 0, 1};
		int ex [7] = '{3, 2, 17, 3, 3, 4, 4};
		// Silent peer: only the programmed waits may end these cycles
		mode = 4'h2;
		cs_cfg.ext_ack_mode = 1'b0;
		cs_cfg.auto_burst_inhibit = 1'b1;
		for (int i = 0; i < 7; i++)
		begin
			cs_cfg.wait_states = 4'(ws[i]);
			cs_cfg.relaxed_timing_bit = rl[i][0];
			cs_cfg.cs_delay_field = 2'(dl[i]);
			cs_cfg.extended_hold_bit = eh[i][0];
			cs_cfg.early_negate_bit = en[i][0];
			inh_seen = 1'b0;
			cs_cnt = 0;
			xfer(32'h8000_0200, SCBC_SIZE_WORD, 1'b1, 1'b0, 32'hC001_D00D, 1);
			chk("w_len", rsp_cyc - st_cyc, ex[i]);
			chk("w_inh", inh_seen, 1);
			chk("w_cs", cs_cnt, ws[i] + 1 - en[i]);
		end
	endtask

	initial
	begin
		srst = 1'b1;
		req_valid = 1'b0;
		req = '0;
		mode = 4'h0;
		lat = 4'h0;
		inhibit = 1'b0;
		prev_st = -10;
		cs_cfg = '0;
		cs_cfg.cs_base_setting = 32'h8000_0000;
		cs_cfg.cs_mask = 32'hF000_0000;
		cs_cfg.ext_ack_mode = 1'b1;
		repeat (5) @(negedge mclk);
		chk("rst_start", transfer_start_n, 1);
		chk("rst_rv", rsp_valid, 0);
		srst = 1'b0;
		t_read();
		t_write();
		t_faults();
		t_burst();
		t_waits();
		final_report();
	end
endmodule // tb_top
